// *** design/irsl_link_setup.v ***
// Connection setup controller for an infrared secondary station.
`timescale 1ns/1ps
`include "irsl_defs.vh"

module irsl_link_setup (
    clk,
    rstn,
    rx_valid,
    rx_kind,
    rx_num,
    rx_busy,
    rx_peer_rate,
    rx_query,
    tx_done,
    link_closed,
    tx_start_q,
    tx_kind_q,
    tx_b0_q,
    tx_b1_q,
    tx_b2_q,
    tx_b3_q,
    tx_b4_q,
    link_rate_q,
    cts_q,
    disconnected_state_q,
    discovery_q,
    connected_state_q
);
    // ------------------------------------------------------------------
    // Ports
    // ------------------------------------------------------------------
    input wire clk;                  // System clock, 100 MHz.
    input wire rstn;                 // Asynchronous reset, active low.
    input wire rx_valid;             // Pulse: a decoded frame arrived.
    input wire [2:0] rx_kind;        // Kind of the arrived frame.
    input wire [7:0] rx_num;         // Polling packet number.
    input wire rx_busy;              // Level: receiver sees a frame.
    input wire [7:0] rx_peer_rate;   // Primary's rate bitmap.
    input wire [1:0] rx_query;       // Query selector.
    input wire tx_done;              // Pulse: encoder finished a reply.
    input wire link_closed;          // Pulse: connected phase ended.
    output reg tx_start_q;           // Pulse: send the reply below.
    output reg [2:0] tx_kind_q;      // Reply kind.
    output reg [7:0] tx_b0_q;        // Reply field 0.
    output reg [7:0] tx_b1_q;        // Reply field 1.
    output reg [7:0] tx_b2_q;        // Reply field 2.
    output reg [7:0] tx_b3_q;        // Reply field 3.
    output reg [7:0] tx_b4_q;        // Reply field 4.
    output wire [7:0] link_rate_q;   // One-hot link rate.
    output reg cts_q;                // High holds the host off.
    output reg disconnected_state_q; // In the disconnected phase.
    output reg discovery_q;          // In the discovery phase.
    output reg connected_state_q;    // Discovery finished.

    // ------------------------------------------------------------------
    // States
    // ------------------------------------------------------------------
    localparam [1:0] ST_DISC = 2'h0;  // Polling, no link.
    localparam [1:0] ST_PARM = 2'h1;  // Discovery, parameter exchange.
    localparam [1:0] ST_QRY = 2'h2;   // Discovery, service queries.
    localparam [1:0] ST_CONN = 2'h3;  // Handed over to data exchange.

    reg [1:0] state_q;     // Current phase.
    reg [1:0] state_d;     // Next phase.
    reg xid_sent_q;        // XID answer sent in this poll round.
    reg xid_sent_d;        // Next value of the XID flag.
    reg busy_q;            // An own reply is on the link.
    reg busy_d;            // Next value of the reply-busy flag.
    reg rate_load;         // Latch negotiated rate this cycle.
    reg start_d;           // Launch a reply this cycle.
    reg [2:0] kind_d;      // Kind of the reply launched.
    reg [7:0] b0_d;        // Reply field 0.
    reg [7:0] b1_d;        // Reply field 1.
    reg [7:0] b2_d;        // Reply field 2.
    reg [7:0] b3_d;        // Reply field 3.
    reg [7:0] b4_d;        // Reply field 4.
    wire can_tx;           // Link idle in both directions.

    // ------------------------------------------------------------------
    // Rate negotiation
    // ------------------------------------------------------------------
    // default then capped
    irsl_rate_pick u_rate (
        .clk(clk),
        .rstn(rstn),
        .load(rate_load),
        .peer_caps(rx_peer_rate),
        .own_caps(`IRSL_RATE_CAPS),
        .rate_q(link_rate_q)
    );

    assign can_tx = !rx_busy && !busy_q;

    // ------------------------------------------------------------------
    // Phase sequencing and reply selection
    // ------------------------------------------------------------------
    // Decides the next phase and which reply, if any, to launch. All
    // replies are built here; the host is never asked for any of them.
    always @* begin
        state_d = state_q;
        xid_sent_d = xid_sent_q;
        busy_d = busy_q;
        rate_load = 1'b0;
        start_d = 1'b0;
        kind_d = `IRSL_R_NONE;
        b0_d = 8'h00;
        b1_d = 8'h00;
        b2_d = 8'h00;
        b3_d = 8'h00;
        b4_d = 8'h00;
        // A finished reply frees the link for the next exchange.
        if (tx_done) begin
            busy_d = 1'b0;
        end
        case (state_q)
            ST_DISC: begin
                if (rx_valid && rx_kind == `IRSL_K_POLL &&
                    rx_num == `IRSL_MY_SLOT && can_tx) begin
                    start_d = 1'b1;
                    kind_d = `IRSL_R_XID;
                    b0_d = `IRSL_MY_SLOT;
                    b1_d = `IRSL_SVC_9WIRE;
                    xid_sent_d = 1'b1;
                    busy_d = 1'b1;
                end else if (rx_valid && rx_kind == `IRSL_K_BCAST_ID) begin
                    if (xid_sent_q) begin
                        state_d = ST_PARM;
                    end
                    xid_sent_d = 1'b0;
                end
            end
            ST_PARM: begin
                if (rx_valid && rx_kind == `IRSL_K_PARAM && can_tx) begin
                    rate_load = 1'b1;
                    start_d = 1'b1;
                    kind_d = `IRSL_R_PARAM;
                    b0_d = `IRSL_RATE_CAPS;
                    b1_d = `IRSL_TURN_CAP;
                    b2_d = `IRSL_WINDOW_CAP;
                    b3_d = `IRSL_DISC_CAP;
                    busy_d = 1'b1;
                    state_d = ST_QRY;
                end else if (rx_valid && rx_kind == `IRSL_K_DISC) begin
                    state_d = ST_DISC;
                end
            end
            ST_QRY: begin
                if (rx_valid && rx_kind == `IRSL_K_QUERY && can_tx) begin
                    start_d = 1'b1;
                    kind_d = `IRSL_R_QUERY;
                    b0_d = {6'h00, rx_query};
                    case (rx_query)
                        `IRSL_Q_NAME: b1_d = `IRSL_SVC_9WIRE;
                        `IRSL_Q_ADDR: b1_d = `IRSL_SVC_ADDR;
                        `IRSL_Q_CAPS: begin
                            b1_d = `IRSL_SVC_9WIRE;
                            b2_d = `IRSL_RATE_CAPS;
                        end
                        default: b1_d = 8'h00;
                    endcase
                    busy_d = 1'b1;
                end else if (rx_valid && rx_kind == `IRSL_K_CONNECT &&
                             can_tx) begin
                    start_d = 1'b1;
                    kind_d = `IRSL_R_CONNECT;
                    busy_d = 1'b1;
                    state_d = ST_CONN;
                end else if (rx_valid && rx_kind == `IRSL_K_DISC) begin
                    state_d = ST_DISC;
                end
            end
            ST_CONN: begin
                // Data exchange lives elsewhere; wait for it to close.
                if (link_closed) begin
                    state_d = ST_DISC;
                    xid_sent_d = 1'b0;
                end
            end
            default: begin
                state_d = ST_DISC;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // State and output registers
    // ------------------------------------------------------------------
    // Outputs are registered; CTS stays high until data exchange opens.
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_q <= ST_DISC;
            xid_sent_q <= 1'b0;
            busy_q <= 1'b0;
            tx_start_q <= 1'b0;
            tx_kind_q <= `IRSL_R_NONE;
            tx_b0_q <= 8'h00;
            tx_b1_q <= 8'h00;
            tx_b2_q <= 8'h00;
            tx_b3_q <= 8'h00;
            tx_b4_q <= 8'h00;
            cts_q <= 1'b1;
            disconnected_state_q <= 1'b1;
            discovery_q <= 1'b0;
            connected_state_q <= 1'b0;
        end else begin
            state_q <= state_d;
            xid_sent_q <= xid_sent_d;
            busy_q <= busy_d;
            tx_start_q <= start_d;
            if (start_d) begin
                tx_kind_q <= kind_d;
                tx_b0_q <= b0_d;
                tx_b1_q <= b1_d;
                tx_b2_q <= b2_d;
                tx_b3_q <= b3_d;
                tx_b4_q <= b4_d;
            end
            cts_q <= (state_d != ST_CONN);
            disconnected_state_q <= (state_d == ST_DISC);
            discovery_q <= (state_d == ST_PARM) || (state_d == ST_QRY);
            connected_state_q <= (state_d == ST_CONN);
        end
    end
endmodule // irsl_link_setup

// *** design/irsl_rate_pick.v ***
// Picks the fastest rate common to both stations from a capability mask.
`timescale 1ns/1ps
`include "irsl_defs.vh"

module irsl_rate_pick (
    clk,
    rstn,
    load,
    peer_caps,
    own_caps,
    rate_q
);
    // ------------------------------------------------------------------
    // Ports
    // ------------------------------------------------------------------
    input wire clk;             // System clock.
    input wire rstn;            // Asynchronous reset, active low.
    input wire load;            // Pulse: latch a newly negotiated rate.
    input wire [7:0] peer_caps; // Rate bitmap offered by the primary.
    input wire [7:0] own_caps;  // Rate bitmap this station supports.
    output reg [7:0] rate_q;    // One-hot agreed rate.

    // ------------------------------------------------------------------
    // Highest common bit
    // ------------------------------------------------------------------
    reg [7:0] common;  // Rates both sides support.
    reg [7:0] rate_d;  // One-hot highest common rate.
    integer i;

    // Scan upward so the highest set bit wins; no match keeps default.
    always @* begin
        common = peer_caps & own_caps;
        rate_d = `IRSL_RATE_DEFAULT;
        for (i = 0; i < 8; i = i + 1) begin
            if (common[i]) begin
                rate_d = 8'h01 << i;
            end
        end
    end

    // The agreed rate resets to the default rate.
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rate_q <= `IRSL_RATE_DEFAULT;
        end else if (load) begin
            rate_q <= rate_d;
        end
    end
endmodule // irsl_rate_pick

// *** inc/irsl_defs.vh ***
// Constants for the infrared secondary link setup controller.
`ifndef IRSL_DEFS_VH
`define IRSL_DEFS_VH

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
// System clock rate in Hz.
`define IRSL_CLK_HZ 100000000
// Default link rate in baud, used from reset until the first parameter exchange; later polling keeps the last agreed rate.
`define IRSL_DEFAULT_BAUD 9600
// Cycles per bit at the default rate (rounded down).
`define IRSL_BIT_CYC (`IRSL_CLK_HZ / `IRSL_DEFAULT_BAUD)

// ----------------------------------------------------------------------
// Polling and frame kinds
// ----------------------------------------------------------------------
// Polling packet number that this station answers.
`define IRSL_MY_SLOT 8'h02
// Received frame kinds reported by the frame decoder.
`define IRSL_K_POLL 3'h0
`define IRSL_K_BCAST_ID 3'h1
`define IRSL_K_PARAM 3'h2
`define IRSL_K_QUERY 3'h3
`define IRSL_K_CONNECT 3'h4
`define IRSL_K_DISC 3'h5
// Reply kinds handed to the frame encoder.
`define IRSL_R_NONE 3'h0
`define IRSL_R_XID 3'h1
`define IRSL_R_PARAM 3'h2
`define IRSL_R_QUERY 3'h3
`define IRSL_R_CONNECT 3'h4

// ----------------------------------------------------------------------
// Link parameters
// ----------------------------------------------------------------------
// Rate capability bitmap: bit0 9.6k, bit1 19.2k, bit2 38.4k,
// bit3 57.6k, bit4 115.2k; nothing above 115.2k is ever offered.
`define IRSL_RATE_CAPS 8'h1f
// Rate mask for the default rate.
`define IRSL_RATE_DEFAULT 8'h01
// Own turnaround, window size and disconnect time codes.
`define IRSL_TURN_CAP 8'h01
`define IRSL_WINDOW_CAP 8'h01
`define IRSL_DISC_CAP 8'h02
// Service class code for nine-wire cooked serial emulation.
`define IRSL_SVC_9WIRE 8'h04

// ----------------------------------------------------------------------
// Query selectors
// ----------------------------------------------------------------------
`define IRSL_Q_NAME 2'h0
`define IRSL_Q_ADDR 2'h1
`define IRSL_Q_CAPS 2'h2
// Service address answered for the serial service.
`define IRSL_SVC_ADDR 8'h01

`endif

// *** verif/irsl_link_setup_monitor.sv ***
// Assertions on the ports of the link setup controller.
`timescale 1ns/1ps
`include "irsl_defs.vh"

module irsl_link_setup_monitor (
    input wire clk,
    input wire rstn,
    input wire rx_valid,
    input wire [2:0] rx_kind,
    input wire [7:0] rx_num,
    input wire rx_busy,
    input wire [1:0] rx_query,
    input wire tx_done,
    input wire tx_start_q,
    input wire [2:0] tx_kind_q,
    input wire [7:0] tx_b0_q,
    input wire [7:0] tx_b1_q,
    input wire [7:0] link_rate_q,
    input wire cts_q,
    input wire disconnected_state_q,
    input wire discovery_q,
    input wire connected_state_q
);
    reg pend_q; // A reply is under way.
    reg parm_q; // Parameter reply already sent in this discovery.
    wire ok; // A frame that must be answered.
    assign ok = rx_valid && !rx_busy && !pend_q && !tx_start_q && !tx_done;

    // Follows each reply from its start to its end.
    always @(posedge clk or negedge rstn) begin
        if (!rstn)
            pend_q <= 1'b0;
        else if (tx_start_q)
            pend_q <= 1'b1;
        else if (tx_done)
            pend_q <= 1'b0;
    end

    // Tells the parameter step of discovery from the query step.
    always @(posedge clk or negedge rstn) begin
        if (!rstn)
            parm_q <= 1'b0;
        else if (!discovery_q)
            parm_q <= 1'b0;
        else if (tx_start_q && tx_kind_q == `IRSL_R_PARAM)
            parm_q <= 1'b1;
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);

    a_xid_slot_two: assert property (
        ok && disconnected_state_q && rx_kind == `IRSL_K_POLL
        && rx_num == `IRSL_MY_SLOT |=> tx_start_q
        && tx_kind_q == `IRSL_R_XID && tx_b0_q == `IRSL_MY_SLOT
        && tx_b1_q == `IRSL_SVC_9WIRE) else $error("no slot reply");
    a_other_poll_quiet: assert property (
        rx_valid && rx_kind == `IRSL_K_POLL && rx_num != `IRSL_MY_SLOT
        |=> !tx_start_q) else $error("reply to foreign slot");
    a_discovery_cause: assert property (
        $rose(discovery_q) |-> $past(rx_valid)
        && $past(rx_kind) == `IRSL_K_BCAST_ID) else $error("bad entry");
    a_host_held: assert property (
        !connected_state_q |-> cts_q) else $error("host released early");
    a_param_reply: assert property (
        ok && discovery_q && !parm_q && rx_kind == `IRSL_K_PARAM
        |=> tx_start_q
        && tx_kind_q == `IRSL_R_PARAM && tx_b0_q == `IRSL_RATE_CAPS
        && tx_b1_q == `IRSL_TURN_CAP) else $error("bad param reply");
    a_rate_capped: assert property (
        $onehot(link_rate_q) && (link_rate_q & ~`IRSL_RATE_CAPS) == 8'h00)
        else $error("rate out of range");
    a_query_reply: assert property (
        ok && discovery_q && parm_q && rx_kind == `IRSL_K_QUERY
        |=> tx_start_q
        && tx_kind_q == `IRSL_R_QUERY
        && tx_b0_q == {6'h00, $past(rx_query)}) else $error("bad query");
    a_busy_refused: assert property (
        rx_valid && rx_busy |=> !tx_start_q) else $error("sent while busy");
    a_connect_ends: assert property (
        ok && discovery_q && parm_q && rx_kind == `IRSL_K_CONNECT
        |=> connected_state_q
        && !cts_q && !discovery_q) else $error("connect not taken");

    c_discovery: cover property ($rose(discovery_q));
    c_connected: cover property ($rose(connected_state_q));
    c_refused: cover property (rx_valid && rx_busy);
    c_aborted: cover property ($fell(discovery_q) && disconnected_state_q);
endmodule // irsl_link_setup_monitor

bind irsl_link_setup irsl_link_setup_monitor mon (
    .clk(clk), .rstn(rstn), .rx_valid(rx_valid), .rx_kind(rx_kind),
    .rx_num(rx_num), .rx_busy(rx_busy), .rx_query(rx_query),
    .tx_done(tx_done), .tx_start_q(tx_start_q), .tx_kind_q(tx_kind_q),
    .tx_b0_q(tx_b0_q), .tx_b1_q(tx_b1_q), .link_rate_q(link_rate_q),
    .cts_q(cts_q), .disconnected_state_q(disconnected_state_q),
    .discovery_q(discovery_q), .connected_state_q(connected_state_q)
);

// *** verif/irsl_link_setup_test.sv ***
// Self-checking bench for the link setup controller.
`timescale 1ns/1ps
`include "irsl_defs.vh"

module irsl_link_setup_test;
    reg clk = 1'b0;
    reg rstn = 1'b0;
    wire rx_valid, rx_busy, tx_done, tx_start_q, cts_q, dis_q, dsc_q, con_q;
    wire [2:0] rx_kind, tx_kind_q;
    wire [1:0] rx_query;
    wire [7:0] rx_num, rx_peer_rate, b0, b1, b2, b3, b4, link_rate_q;
    integer miscompares = 0;
    integer checked = 0;
    integer i;
    reg [7:0] n0;

    irsl_link_setup dut (
        .clk(clk), .rstn(rstn), .rx_valid(rx_valid), .rx_kind(rx_kind),
        .rx_num(rx_num), .rx_busy(rx_busy), .rx_peer_rate(rx_peer_rate),
        .rx_query(rx_query), .tx_done(tx_done), .link_closed(1'b0),
        .tx_start_q(tx_start_q), .tx_kind_q(tx_kind_q), .tx_b0_q(b0),
        .tx_b1_q(b1), .tx_b2_q(b2), .tx_b3_q(b3), .tx_b4_q(b4),
        .link_rate_q(link_rate_q), .cts_q(cts_q),
        .disconnected_state_q(dis_q), .discovery_q(dsc_q),
        .connected_state_q(con_q));
    irsl_primary_model pri (
        .clk(clk), .tx_start_q(tx_start_q), .rx_valid(rx_valid),
        .rx_kind(rx_kind), .rx_num(rx_num), .rx_busy(rx_busy),
        .rx_peer_rate(rx_peer_rate), .rx_query(rx_query), .tx_done(tx_done));

    // Compares one value and counts the result.
    task chk(input [7:0] got, input [7:0] exp);
        begin
            checked = checked + 1;
            if (got !== exp) begin
                miscompares = miscompares + 1;
                $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask

    // Prints the verdict and ends the run.
    task test_done;
        begin
            if (miscompares == 0 && checked > 0)
                $display("DONE - PASS");
            else
                $display("DONE - FAIL");
            $finish;
        end
    endtask

    // One polling round, with or without slot two, then maybe the ID.
    task t_round(input two, input id);
        begin
            n0 = pri.n_start;
            for (i = 0; i < 8; i = i + 1)
                if (i != 2 || two)
                    pri.send(`IRSL_K_POLL, i[7:0], 8'h00, 2'h0, 1'b0);
            chk(pri.n_start - n0, {7'h00, two});
            if (two) begin
                chk(tx_kind_q, `IRSL_R_XID);
                chk(b0, `IRSL_MY_SLOT);
                chk(b1, `IRSL_SVC_9WIRE);
            end
            if (id)
                pri.send(`IRSL_K_BCAST_ID, 8'h00, 8'h00, 2'h0, 1'b0);
            chk({dsc_q, dis_q, cts_q}, {5'h00, id & two, ~(id & two), 1'b1});
        end
    endtask

    // A busy frame is refused; then the common rate is chosen.
    task t_param;
        begin
            n0 = pri.n_start;
            pri.send(`IRSL_K_PARAM, 8'h00, 8'he6, 2'h0, 1'b1);
            chk(pri.n_start - n0, 8'h00);
            chk(link_rate_q, `IRSL_RATE_DEFAULT);
            pri.send(`IRSL_K_PARAM, 8'h00, 8'he6, 2'h0, 1'b0);
            chk(pri.n_start - n0, 8'h01);
            chk(tx_kind_q, `IRSL_R_PARAM);
            chk(b0, `IRSL_RATE_CAPS);
            chk(b1, `IRSL_TURN_CAP);
            chk(b2, `IRSL_WINDOW_CAP);
            chk(b3, `IRSL_DISC_CAP);
            chk(b4, 8'h00);
            chk(link_rate_q, 8'h04);
        end
    endtask

    // Every service question is answered, with a slow partner.
    task t_query;
        begin
            pri.gap = 20;
            for (i = 0; i < 4; i = i + 1) begin
                pri.send(`IRSL_K_QUERY, 8'h00, 8'h00, i[1:0], 1'b0);
                chk(tx_kind_q, `IRSL_R_QUERY);
                chk(b0, i[7:0]);
                if (i == 3)
                    chk(b1, 8'h00);
                else
                    chk(b1, (i == 1) ? `IRSL_SVC_ADDR : `IRSL_SVC_9WIRE);
                chk(b2, (i == 2) ? `IRSL_RATE_CAPS : 8'h00);
            end
            chk(cts_q, 1'b1);
            pri.gap = 1;
        end
    endtask

    initial forever #5 clk = ~clk;

    // Main sequence.
    initial begin
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        #1;
        chk({cts_q, dis_q, link_rate_q[0]}, 8'h07);
        t_round(1'b0, 1'b1);
        t_round(1'b1, 1'b0);
        t_round(1'b1, 1'b1);
        // A disconnect in discovery falls back to polling.
        pri.send(`IRSL_K_DISC, 8'h00, 8'h00, 2'h0, 1'b0);
        chk({dsc_q, dis_q, cts_q}, 8'h03);
        t_round(1'b1, 1'b1);
        t_param;
        t_query;
        pri.send(`IRSL_K_CONNECT, 8'h00, 8'h00, 2'h0, 1'b0);
        chk({dsc_q, con_q, cts_q}, 8'h02);
        test_done;
    end

    // Cuts a hang short.
    initial begin
        #200000;
        miscompares = miscompares + 1;
        test_done;
    end
endmodule // irsl_link_setup_test

// *** verif/irsl_primary_model.sv ***
// Behavioural model of the remote primary station.
`timescale 1ns/1ps

module irsl_primary_model (
    input wire clk,
    input wire tx_start_q,
    output reg rx_valid,
    output reg [2:0] rx_kind,
    output reg [7:0] rx_num,
    output reg rx_busy,
    output reg [7:0] rx_peer_rate,
    output reg [1:0] rx_query,
    output reg tx_done
);
    integer gap = 1; // Cycles a reply takes on the link.
    reg [7:0] n_start = 8'h00; // Replies seen so far.

    initial begin
        rx_valid = 1'b0;
        rx_kind = 3'h0;
        rx_num = 8'h00;
        rx_busy = 1'b0;
        rx_peer_rate = 8'h00;
        rx_query = 2'h0;
        tx_done = 1'b0;
    end

    // One frame at a time, in the order the bench calls.
    task send(input [2:0] k, input [7:0] n, input [7:0] r, input [1:0] q,
              input b);
        begin
            @(posedge clk);
            rx_valid <= 1'b1;
            rx_kind <= k;
            rx_num <= n;
            rx_peer_rate <= r;
            rx_query <= q;
            rx_busy <= b;
            @(posedge clk);
            rx_valid <= 1'b0;
            rx_busy <= 1'b0;
            rx_kind <= ~k;
            rx_num <= ~n;
            rx_peer_rate <= ~r;
            rx_query <= ~q;
            repeat (gap + 4) @(posedge clk);
            #1;
        end
    endtask

    // Counts each reply and ends it after the set gap.
    initial forever begin
        @(posedge clk);
        if (tx_start_q) begin
            n_start = n_start + 8'h01;
            repeat (gap) @(posedge clk);
            tx_done <= 1'b1;
            @(posedge clk);
            tx_done <= 1'b0;
        end
    end
endmodule // irsl_primary_model
